// [common/hpc_map.svh]
/*
 * Bit positions, reset values and timing counts of the host port control register.
 * Assumes it is included by bare name from the package and the design files.
 */
`ifndef HPC_MAP_SVH
`define HPC_MAP_SVH

`define HPC_BIT_ADDR_SEL    11
`define HPC_BIT_DUAL_ADDR   9
`define HPC_BIT_HALF_STAT   8
`define HPC_BIT_SOFT_RST    7
`define HPC_BIT_FETCH       4
`define HPC_BIT_READY_IND   3
`define HPC_BIT_TO_HOST_INT 2
`define HPC_BIT_TO_CPU_INT  1
`define HPC_BIT_HALFWORD    0

`define HPC_CTRL_RESET      32'h0000_0000
`define HPC_ADDR_RESET      32'h0000_0000
`define HPC_ADDR_STEP       32'h0000_0001

// FIFO clear time in ns, clock period in ns, and the derived cycle count
`define HPC_FIFO_RST_NS     32
`define HPC_CLK_PERIOD_NS   4
`define HPC_FIFO_RST_CYC    ((`HPC_FIFO_RST_NS + `HPC_CLK_PERIOD_NS - 1) / `HPC_CLK_PERIOD_NS)

`endif

// [common/hpc_pkg.sv]
/*
 * Types of the host port control register block.
 * Assumes hpc_map.svh is on the include path.
 */
`default_nettype none
`include "hpc_map.svh"

package hpc_pkg;

   // One access from the host port front end
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic        sel_addr;
      logic [31:0] wdata;
   } hpc_host_req_t;

   // One access from the on-chip CPU
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [31:0] wdata;
   } hpc_cpu_req_t;

   typedef enum logic [1:0] {
      SR_IDLE,
      SR_WAIT,
      SR_CLEAR,
      SR_HELD
   } hpc_srst_state_t;

endpackage

`default_nettype wire

// [rtl/hpc_sync3.sv]
/*
 * Three-stage synchroniser for one level from outside the clock domain.
 * Assumes clk_sys and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module hpc_sync3 (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // Level
   input  wire logic async_in,
   output logic      sync_out
);

   logic [2:0] stage_reg;

   // Output moves only once stages two and three agree
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stage_reg <= 3'h0;
         sync_out  <= 1'b0;
      end else begin
         stage_reg <= {stage_reg[1:0], async_in};
         if (stage_reg[1] == stage_reg[2]) begin
            sync_out <= stage_reg[2];
         end
      end
   end

endmodule

`default_nettype wire

// [rtl/hpc_port_control.sv]
/*
 * Host port control and status register with address registers and soft FIFO reset.
 * Assumes host and CPU requests arrive as one-cycle strobes on clk_sys; the host
 * cycle activity level comes from a pin and is synchronised here.
 */
// Operation
// - Single mode: host address write loads read and write address registers.
// - Single mode: each autoincrement advances both address registers together.
// - Single mode: host address read returns the read address register.
// - Dual mode: host sees independent read and write address registers.
// - Bit 8 mirrors the halfword order bit, read only.
// - Host reads of the soft reset bit return 0.
// - CPU write 1 to soft reset clears both FIFOs and their logic.
// - A host cycle in progress finishes before the FIFO reset starts.
// - CPU reads soft reset as 0 until the FIFO reset completes.
// - CPU write 0 during the reset does not cancel it.
// - While soft reset is 1 the ready pin stays deasserted, except while waiting for the open host cycle to end.
// - Host accesses stay blocked until the CPU writes 0 to soft reset.
// - Host write 1 to fetch bit requests a read FIFO prefetch.
// - Fetch bit always reads 0 for host and CPU.
// - Host reads bit 3 as the internal ready state.
// - CPU reads of the ready indicator return 0.
// - Internal ready indicator is kept apart from the ready pin.
// - CPU write 1 sets the to-host interrupt bit; holds until host clears.
// - Host write 1 clears the to-host interrupt bit.
// - Writing 0 to the to-host interrupt bit changes nothing.
// - To-CPU interrupt bit: host sets it, only CPU clears it.
// - Host write 1 raises the CPU interrupt; CPU write 1 clears it.
// - Dual mode: address select 0 picks write register, 1 read register.
`timescale 1ns/1ps
`default_nettype none
`include "hpc_map.svh"

module hpc_port_control
   import hpc_pkg::*;
(
   // Clock and reset
   input  wire logic          clk_sys,
   input  wire logic          rst,
   // Host side
   input  wire hpc_host_req_t host_req,
   output logic [31:0]        host_rdata,
   input  wire logic          host_cycle_pin,
   output logic               host_ready_pin,
   output logic               host_int_out,
   // CPU side
   input  wire hpc_cpu_req_t  cpu_req,
   output logic [31:0]        cpu_rdata,
   output logic               cpu_int_out,
   // Datapath
   input  wire logic          dp_ready,
   input  wire logic          incr_rd,
   input  wire logic          incr_wr,
   output logic [31:0]        read_address,
   output logic [31:0]        write_address,
   output logic               halfword_order,
   output logic               fifo_reset,
   output logic               prefetch_req
);

   localparam logic [3:0] FIFO_RST_CYC = 4'(`HPC_FIFO_RST_CYC);

   logic [31:0]     read_address_reg;
   logic [31:0]     read_address_next;
   logic [31:0]     write_address_reg;
   logic [31:0]     write_address_next;
   logic            dual_address_mode_reg;
   logic            address_select_reg;
   logic            halfword_order_reg;
   logic            to_host_int_reg;
   logic            to_host_int_next;
   logic            to_cpu_int_reg;
   logic            to_cpu_int_next;
   logic            soft_reset_reg;
   logic            soft_reset_next;
   logic            ready_ind_reg;
   logic            ready_pin_next;
   logic            fifo_reset_reg;
   logic            prefetch_reg;
   logic [31:0]     host_rdata_reg;
   logic [31:0]     cpu_rdata_reg;
   logic [3:0]      clr_cnt_reg;
   logic [3:0]      clr_cnt_next;
   logic            host_busy;
   hpc_srst_state_t state_reg;
   hpc_srst_state_t state_next;

   hpc_sync3 u_busy_sync (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .async_in (host_cycle_pin),
      .sync_out (host_busy)
   );

   // Request decode
   wire host_ctrl_wr = host_req.wr & ~host_req.sel_addr;
   wire host_addr_wr = host_req.wr &  host_req.sel_addr;
   wire cpu_wr       = cpu_req.wr;
   wire [31:0] hwd   = host_req.wdata;
   wire [31:0] cwd   = cpu_req.wdata;

   wire host_sets_cpu_int  = host_ctrl_wr & hwd[`HPC_BIT_TO_CPU_INT];
   wire cpu_clrs_cpu_int   = cpu_wr & cwd[`HPC_BIT_TO_CPU_INT];
   wire cpu_sets_host_int  = cpu_wr & cwd[`HPC_BIT_TO_HOST_INT];
   wire host_clrs_host_int = host_ctrl_wr & hwd[`HPC_BIT_TO_HOST_INT];
   wire cpu_srst_one       = cpu_wr & cwd[`HPC_BIT_SOFT_RST];
   wire cpu_srst_zero      = cpu_wr & ~cwd[`HPC_BIT_SOFT_RST];

   // Set has priority over clear on both interrupt bits
   assign to_host_int_next = cpu_sets_host_int ? 1'b1 :
                             host_clrs_host_int ? 1'b0 : to_host_int_reg;
   assign to_cpu_int_next  = host_sets_cpu_int ? 1'b1 :
                             cpu_clrs_cpu_int ? 1'b0 : to_cpu_int_reg;

   // Address write target and increments
   wire addr_to_read  = ~dual_address_mode_reg | address_select_reg;
   wire addr_to_write = ~dual_address_mode_reg | ~address_select_reg;
   wire step_read     = dual_address_mode_reg ? incr_rd : (incr_rd | incr_wr);
   wire step_write    = dual_address_mode_reg ? incr_wr : (incr_rd | incr_wr);

   assign read_address_next  = (host_addr_wr & addr_to_read) ? hwd :
                               step_read ? read_address_reg + `HPC_ADDR_STEP :
                               read_address_reg;
   assign write_address_next = (host_addr_wr & addr_to_write) ? hwd :
                               step_write ? write_address_reg + `HPC_ADDR_STEP :
                               write_address_reg;

   // Soft reset sequence: wait for the host cycle, clear FIFOs, hold host off
   always_comb begin
      state_next   = state_reg;
      clr_cnt_next = clr_cnt_reg;
      case (state_reg)
         SR_IDLE: begin
            if (cpu_srst_one) begin
               state_next   = host_busy ? SR_WAIT : SR_CLEAR;
               clr_cnt_next = FIFO_RST_CYC - 4'h1;
            end
         end
         SR_WAIT: begin
            if (!host_busy) begin
               state_next = SR_CLEAR;
            end
         end
         SR_CLEAR: begin
            if (clr_cnt_reg == 4'h0) begin
               state_next = SR_HELD;
            end else begin
               clr_cnt_next = clr_cnt_reg - 4'h1;
            end
         end
         SR_HELD: begin
            if (cpu_srst_zero) begin
               state_next = SR_IDLE;
            end
         end
         default: begin
            state_next = SR_IDLE;
         end
      endcase
   end

   // A zero write only lands once the clear has finished
   assign soft_reset_next = cpu_srst_one ? 1'b1 :
                            (cpu_srst_zero & state_reg == SR_HELD) ? 1'b0 :
                            soft_reset_reg;

   // The pin stays ready only while the pending host cycle drains
   wire hold_off = (state_next == SR_CLEAR) | (state_next == SR_HELD) |
                   (soft_reset_next & state_next != SR_WAIT);
   assign ready_pin_next = dp_ready & ~hold_off;

   // Read views for each party
   wire [31:0] ctrl_common = {20'h0_0000,
                              address_select_reg, 1'b0, dual_address_mode_reg,
                              halfword_order_reg,
                              1'b0, 2'b00, 1'b0, 1'b0,
                              to_host_int_reg, to_cpu_int_reg, halfword_order_reg};
   wire [31:0] host_ctrl_view = ctrl_common |
                                {28'h000_0000, ready_ind_reg, 3'h0};
   wire soft_reset_seen = soft_reset_reg & (state_reg == SR_HELD);
   wire [31:0] cpu_ctrl_view = ctrl_common |
                               {24'h00_0000, soft_reset_seen, 7'h00};
   wire [31:0] host_addr_view = (~dual_address_mode_reg | address_select_reg) ?
                                read_address_reg : write_address_reg;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         read_address_reg  <= `HPC_ADDR_RESET;
         write_address_reg <= `HPC_ADDR_RESET;
      end else begin
         read_address_reg  <= read_address_next;
         write_address_reg <= write_address_next;
      end
   end

   // Host owns the mode bits; reserved bits are not stored
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dual_address_mode_reg <= 1'b0;
         address_select_reg    <= 1'b0;
         halfword_order_reg    <= 1'b0;
      end else if (host_ctrl_wr) begin
         dual_address_mode_reg <= hwd[`HPC_BIT_DUAL_ADDR];
         address_select_reg    <= hwd[`HPC_BIT_ADDR_SEL];
         halfword_order_reg    <= hwd[`HPC_BIT_HALFWORD];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         to_host_int_reg <= 1'b0;
         to_cpu_int_reg  <= 1'b0;
         prefetch_reg    <= 1'b0;
      end else begin
         to_host_int_reg <= to_host_int_next;
         to_cpu_int_reg  <= to_cpu_int_next;
         prefetch_reg    <= host_ctrl_wr & hwd[`HPC_BIT_FETCH];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg      <= SR_IDLE;
         clr_cnt_reg    <= 4'h0;
         soft_reset_reg <= 1'b0;
         fifo_reset_reg <= 1'b0;
         ready_ind_reg  <= 1'b0;
         host_ready_pin <= 1'b0;
      end else begin
         state_reg      <= state_next;
         clr_cnt_reg    <= clr_cnt_next;
         soft_reset_reg <= soft_reset_next;
         fifo_reset_reg <= (state_next == SR_CLEAR);
         ready_ind_reg  <= dp_ready;
         host_ready_pin <= ready_pin_next;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         host_rdata_reg <= 32'h0000_0000;
         cpu_rdata_reg  <= 32'h0000_0000;
      end else begin
         if (host_req.rd) begin
            host_rdata_reg <= host_req.sel_addr ? host_addr_view : host_ctrl_view;
         end
         if (cpu_req.rd) begin
            cpu_rdata_reg <= cpu_ctrl_view;
         end
      end
   end

   assign host_rdata     = host_rdata_reg;
   assign cpu_rdata      = cpu_rdata_reg;
   assign host_int_out   = to_host_int_reg;
   assign cpu_int_out    = to_cpu_int_reg;
   assign read_address   = read_address_reg;
   assign write_address  = write_address_reg;
   assign halfword_order = halfword_order_reg;
   assign fifo_reset     = fifo_reset_reg;
   assign prefetch_req   = prefetch_reg;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence srst_req_s;
      cpu_srst_one && state_reg == SR_IDLE && !host_busy;
   endsequence
   sequence clear_run_s;
      fifo_reset_reg [*8];
   endsequence

   single_addr_load_a: assert property (host_addr_wr && !dual_address_mode_reg |=>
      read_address_reg == $past(hwd) && write_address_reg == $past(hwd))
      else $error("Single mode address write did not load both registers");
   single_step_a: assert property (!dual_address_mode_reg && !host_addr_wr &&
      (incr_rd || incr_wr) |=> read_address_reg == $past(read_address_reg) + 1 &&
      write_address_reg == $past(write_address_reg) + 1)
      else $error("Single mode step did not move both registers");
   host_addr_read_a: assert property (host_req.rd && host_req.sel_addr &&
      !dual_address_mode_reg |=> host_rdata == $past(read_address_reg))
      else $error("Single mode address read did not return read register");
   dual_select_a: assert property (host_addr_wr && dual_address_mode_reg &&
      !address_select_reg |=> write_address_reg == $past(hwd) &&
      read_address_reg == $past(read_address_reg) + {31'h0, $past(incr_rd)})
      else $error("Dual mode write did not target only write register");
   host_view_a: assert property (host_req.rd && !host_req.sel_addr |=>
      host_rdata[7] == 1'b0 && host_rdata[4] == 1'b0 &&
      host_rdata[8] == $past(halfword_order_reg))
      else $error("Host control read shows wrong fixed bits");
   cpu_view_a: assert property (cpu_req.rd |=> cpu_rdata[3] == 1'b0 &&
      cpu_rdata[4] == 1'b0)
      else $error("CPU control read shows ready or fetch");
   fifo_clear_a: assert property (srst_req_s |=> clear_run_s ##1 !fifo_reset_reg)
      else $error("FIFO clear did not run for the set time");
   wait_host_a: assert property (state_reg == SR_WAIT && host_busy |=>
      !fifo_reset_reg)
      else $error("FIFO clear began during a host cycle");
   srst_hidden_a: assert property (cpu_req.rd && state_reg != SR_HELD |=>
      cpu_rdata[7] == 1'b0)
      else $error("Soft reset read as one before the clear finished");
   no_abort_a: assert property (state_reg == SR_CLEAR && cpu_srst_zero |=>
      state_reg inside {SR_CLEAR, SR_HELD})
      else $error("Zero write cancelled the soft reset");
   ready_hold_a: assert property (soft_reset_reg && state_reg != SR_WAIT |->
      !host_ready_pin)
      else $error("Ready pin asserted while soft reset held");
   host_release_a: assert property (state_reg == SR_HELD && !cpu_srst_zero |=>
      !host_ready_pin)
      else $error("Host released without a zero write");
   host_int_a: assert property (cpu_sets_host_int |=> to_host_int_reg && host_int_out)
      else $error("To-host interrupt set was lost");
   host_int_keep_a: assert property (!cpu_sets_host_int && !host_clrs_host_int |=>
      $stable(to_host_int_reg))
      else $error("To-host interrupt changed without a one write");
   cpu_int_a: assert property (host_sets_cpu_int |=> cpu_int_out)
      else $error("To-CPU interrupt set was lost");
   cpu_int_clr_a: assert property (cpu_clrs_cpu_int && !host_sets_cpu_int |=>
      !to_cpu_int_reg)
      else $error("CPU one write did not clear to-CPU interrupt");
   fetch_pulse_a: assert property (host_ctrl_wr && hwd[`HPC_BIT_FETCH] |=>
      prefetch_req)
      else $error("Fetch write did not give a prefetch pulse");
   fetch_quiet_a: assert property (!(host_ctrl_wr && hwd[`HPC_BIT_FETCH]) |=>
      !prefetch_req)
      else $error("Prefetch pulse without a fetch write");
   cpu_mirror_a: assert property (cpu_req.rd |=>
      cpu_rdata[8] == $past(halfword_order_reg) && cpu_rdata[0] == $past(halfword_order_reg))
      else $error("CPU read shows wrong halfword order status");
   ready_ind_a: assert property (host_req.rd && !host_req.sel_addr && !$past(rst) |=>
      host_rdata[3] == $past(dp_ready, 2))
      else $error("Host read shows wrong internal ready state");
   srst_done_a: assert property (state_reg == SR_HELD && cpu_req.rd |=>
      cpu_rdata[7])
      else $error("Soft reset not read as one after the clear");
   host_int_clr_a: assert property (host_clrs_host_int && !cpu_sets_host_int |=>
      !host_int_out)
      else $error("Host one write did not clear to-host interrupt");
   clear_start_a: assert property (state_reg == SR_WAIT && !host_busy |=>
      fifo_reset_reg)
      else $error("FIFO clear did not start after the host cycle");

endmodule

`default_nettype wire

// [tb/hpc_host_model.sv]
/*
 * Behavioural host on the parallel host port: register strobes and cycle level.
 * Assumes a single clk_sys; the caller enters each task just after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none

module hpc_host_model
   import hpc_pkg::*;
(
   // Clock
   input  wire logic        clk_sys,
   // Requests toward the port
   output var hpc_host_req_t host_req,
   output logic             host_cycle_pin,
   // Answers
   input  wire logic [31:0] host_rdata
);
   initial begin
      host_req = '0;
      host_req.wdata = 32'h5A5A_5A5A;
      host_cycle_pin = 1'b0;
   end

   // Released data shows the inverse so a stale value never looks valid
   task automatic write(input logic sel, input logic [31:0] d);
      host_req.sel_addr = sel;
      host_req.wdata = sel ? d : (d & 32'hFFFF_FF9F);
      host_req.wr = 1'b1;
      @(posedge clk_sys);
      #1;
      host_req.wr = 1'b0;
      host_req.wdata = ~host_req.wdata;
      host_req.sel_addr = ~sel;
      // Idle edge so a following call never reassigns in this time step
      @(posedge clk_sys);
      #1;
   endtask

   task automatic read(input logic sel, output logic [31:0] d);
      host_req.sel_addr = sel;
      host_req.rd = 1'b1;
      @(posedge clk_sys);
      #1;
      host_req.rd = 1'b0;
      host_req.sel_addr = ~sel;
      @(posedge clk_sys);
      #1;
      d = host_rdata;
   endtask

   task automatic set_cycle(input logic v);
      host_cycle_pin = v;
   endtask
endmodule

`default_nettype wire

// [tb/tb_hpc_port_control.sv]
/*
 * Self-checking bench of the host port control register.
 * Assumes hpc_pkg, hpc_map.svh and the host model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "hpc_map.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin bad_count++; $display("Error %s expected %h seen %h", nm, ex, got); end end

module tb_hpc_port_control;
   import hpc_pkg::*;
   logic          clk_sys = 1'b0;
   logic          rst = 1'b1;
   hpc_host_req_t host_req;
   hpc_cpu_req_t  cpu_req = '0;
   logic [31:0]   host_rdata, cpu_rdata, read_address, write_address, rd;
   logic          host_cycle_pin, host_ready_pin, host_int_out, cpu_int_out;
   logic          halfword_order, fifo_reset, prefetch_req;
   logic          dp_ready = 1'b1;
   logic          incr_rd = 1'b0;
   logic          incr_wr = 1'b0;
   int            bad_count = 0;
   int            checks = 0;
   int            cycles = 0;
   int            fr_cnt = 0;
   int            pf_cnt = 0;
   int            i;

   hpc_port_control uut (.clk_sys(clk_sys), .rst(rst), .host_req(host_req),
      .host_rdata(host_rdata), .host_cycle_pin(host_cycle_pin),
      .host_ready_pin(host_ready_pin), .host_int_out(host_int_out), .cpu_req(cpu_req),
      .cpu_rdata(cpu_rdata), .cpu_int_out(cpu_int_out), .dp_ready(dp_ready),
      .incr_rd(incr_rd), .incr_wr(incr_wr), .read_address(read_address),
      .write_address(write_address), .halfword_order(halfword_order),
      .fifo_reset(fifo_reset), .prefetch_req(prefetch_req));

   hpc_host_model hm (.clk_sys(clk_sys), .host_req(host_req),
      .host_cycle_pin(host_cycle_pin), .host_rdata(host_rdata));

   always #2 clk_sys = ~clk_sys;

   // Whole run needs well under a thousand cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (fifo_reset) fr_cnt++;
      if (prefetch_req) pf_cnt++;
      if (cycles == 5000) begin
         bad_count++;
         final_report();
      end
   end

   task automatic final_report();
      $display("Checks %0d, errors %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic cpu_wr(input logic [31:0] d);
      cpu_req.wdata = d;
      cpu_req.wr = 1'b1;
      tick(1);
      cpu_req.wr = 1'b0;
      cpu_req.wdata = ~d;
      tick(1);
   endtask

   task automatic cpu_rd(output logic [31:0] d);
      cpu_req.rd = 1'b1;
      tick(1);
      cpu_req.rd = 1'b0;
      tick(1);
      d = cpu_rdata;
   endtask

   task automatic pulse_incr(input logic wr_side);
      if (wr_side) incr_wr = 1'b1;
      else incr_rd = 1'b1;
      tick(1);
      incr_wr = 1'b0;
      incr_rd = 1'b0;
   endtask

   initial begin
      repeat (6) @(posedge clk_sys);
      #1 rst = 1'b0;
      tick(2);
      hm.read(1'b0, rd);
      `CHK("host ctrl reset", 32'h0000_0008, rd)
      cpu_rd(rd);
      `CHK("cpu ctrl reset", 32'h0000_0000, rd)
      // Fetch, to-CPU interrupt and halfword order in one host write
      hm.write(1'b0, 32'h0000_0013);
      `CHK("prefetch pulse", 1, pf_cnt)
      tick(1);
      `CHK("prefetch end", 1, pf_cnt)
      `CHK("cpu int set", 1'b1, cpu_int_out)
      `CHK("halfword order", 1'b1, halfword_order)
      hm.read(1'b0, rd);
      `CHK("host ctrl", 32'h0000_010B, rd)
      cpu_rd(rd);
      `CHK("cpu ctrl", 32'h0000_0103, rd)
      cpu_wr(32'h0000_0E63);
      `CHK("cpu int cleared", 1'b0, cpu_int_out)
      cpu_rd(rd);
      `CHK("cpu write limits", 32'h0000_0101, rd)
      hm.write(1'b0, 32'h0000_0003);
      hm.write(1'b0, 32'h0000_0001);
      `CHK("host cannot clear", 1'b1, cpu_int_out)
      fork
         hm.write(1'b0, 32'h0000_0003);
         cpu_wr(32'h0000_0002);
      join
      `CHK("set beats clear cpu", 1'b1, cpu_int_out)
      cpu_wr(32'h0000_0002);
      `CHK("cpu int ack", 1'b0, cpu_int_out)
      // To-host interrupt
      cpu_wr(32'h0000_0004);
      `CHK("host int set", 1'b1, host_int_out)
      cpu_wr(32'h0000_0000);
      hm.write(1'b0, 32'h0000_0001);
      `CHK("zero writes keep", 1'b1, host_int_out)
      hm.write(1'b0, 32'h0000_0005);
      `CHK("host int ack", 1'b0, host_int_out)
      fork
         hm.write(1'b0, 32'h0000_0005);
         cpu_wr(32'h0000_0004);
      join
      `CHK("set beats clear host", 1'b1, host_int_out)
      hm.write(1'b0, 32'h0000_0005);
      // Single address mode
      hm.write(1'b1, 32'h1234_5678);
      `CHK("single rd addr", 32'h1234_5678, read_address)
      `CHK("single wr addr", 32'h1234_5678, write_address)
      pulse_incr(1'b1);
      `CHK("step rd addr", 32'h1234_5679, read_address)
      `CHK("step wr addr", 32'h1234_5679, write_address)
      hm.read(1'b1, rd);
      `CHK("single addr read", 32'h1234_5679, rd)
      // Dual address mode, select 0 then 1
      hm.write(1'b0, 32'h0000_0201);
      hm.write(1'b1, 32'hAAAA_0000);
      `CHK("dual wr load", 32'hAAAA_0000, write_address)
      `CHK("dual rd kept", 32'h1234_5679, read_address)
      hm.write(1'b0, 32'h0000_0A01);
      hm.write(1'b1, 32'h5555_0000);
      `CHK("dual rd load", 32'h5555_0000, read_address)
      pulse_incr(1'b0);
      `CHK("dual rd step", 32'h5555_0001, read_address)
      `CHK("dual wr kept", 32'hAAAA_0000, write_address)
      hm.read(1'b1, rd);
      `CHK("dual addr read", 32'h5555_0001, rd)
      dp_ready = 1'b0;
      tick(2);
      hm.read(1'b0, rd);
      `CHK("ready bit low", 1'b0, rd[3])
      dp_ready = 1'b1;
      // Soft reset with a host cycle still open
      hm.set_cycle(1'b1);
      tick(5);
      fr_cnt = 0;
      cpu_wr(32'h0000_0080);
      hm.read(1'b0, rd);
      `CHK("host reset bit", 1'b0, rd[7])
      tick(8);
      `CHK("clear waits", 0, fr_cnt)
      hm.set_cycle(1'b0);
      for (i = 0; i < 20 && fifo_reset !== 1'b1; i++) tick(1);
      `CHK("ready in clear", 1'b0, host_ready_pin)
      cpu_wr(32'h0000_0000);
      cpu_rd(rd);
      `CHK("cpu reset bit busy", 1'b0, rd[7])
      for (i = 0; i < 20 && fifo_reset !== 1'b0; i++) tick(1);
      `CHK("clear length", `HPC_FIFO_RST_CYC, fr_cnt)
      cpu_rd(rd);
      `CHK("cpu reset bit done", 1'b1, rd[7])
      hm.read(1'b0, rd);
      `CHK("internal ready", 1'b1, rd[3])
      `CHK("still held", 1'b0, host_ready_pin)
      cpu_wr(32'h0000_0000);
      `CHK("ready again", 1'b1, host_ready_pin)
      final_report();
   end
endmodule

`default_nettype wire
